// ==== hw/pin_sync.sv ====
/*
 Two flip-flop synchroniser for a group of level inputs.
 Assumes the inputs are slow levels from pins; no pulse capture.
*/
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ==========================================================
    // Stage one is only read by stage two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : pin_sync

// ==== hw/ramp_step.sv ====
/*
 One step of a linear speed ramp: moves the present reference toward
 the target by at most one step, never overshooting.
 Assumes signed speeds and an unsigned step; purely combinational.
*/
`timescale 1ns/1ps
module ramp_step (
    // Operands
    input  wire logic signed [31:0] cur_speed,
    input  wire logic signed [31:0] goal_speed,
    input  wire logic        [31:0] step,
    // Result
    output      logic signed [31:0] next_speed
);
    logic signed [33:0] gap;
    logic signed [33:0] step_w;

    // ==========================================================
    // Wide arithmetic so a full-scale reversal cannot wrap
    always_comb begin
        gap    = 34'(goal_speed) - 34'(cur_speed);
        step_w = $signed({2'b00, step});
        if (gap > step_w) begin
            next_speed = 32'(34'(cur_speed) + step_w);
        end else if (gap < -step_w) begin
            next_speed = 32'(34'(cur_speed) - step_w);
        end else begin
            next_speed = goal_speed;
        end
    end

endmodule : ramp_step

// ==== hw/servo_speed_mode_control.sv ====
/*
 Speed operating mode of a servo positioning controller. A write of
 the signed setpoint starts the mode; the speed reference ramps to it
 and holds it with no end position. A status word reports reached,
 finished, error and the cause of a stop.
 Assumes: limit switches, hardware stop and reference error arrive on
 pins; soft limits, soft stop, ramp step and actual speed come from
 logic on the same clock. Parameter accesses are single-cycle strobes.
*/
`timescale 1ns/1ps

// Contract
// R1: Setpoint write enters speed mode, starts acceleration
// R2: Hold commanded speed until new write or fault
// R3: Finished when speed difference zero or fault
// R4: Setpoint register signed 32-bit, RW, default zero
// R5: Status bits 13 reached, 14 end, 15 error
// R6: Status bits 0-3, 5-7 give stop causes
// R7: New setpoint accepted while moving, no stop
// R8: Positioning range limits never stop speed mode
// R9: Ramp values latched only at setpoint write
// R10: Reset clears status, zero setpoint, stays idle
module servo_speed_mode_control
    import speed_mode_pkg::*;
(
    // Clock and reset
    input  wire logic                CLK,
    input  wire logic                RST_N,
    // Parameter access port
    input  wire logic [7:0]          REG_INDEX,
    input  wire logic [7:0]          REG_SUBINDEX,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    input  wire logic [31:0]         REG_WDATA,
    output      logic [31:0]         REG_RDATA,
    output      logic                REG_RVALID,
    output      logic                REG_ERR,
    // Stop cause pins
    input  wire logic                POSITIVE_LIMIT_SWITCH,
    input  wire logic                NEGATIVE_LIMIT_SWITCH,
    input  wire logic                HARDWARE_STOP_INPUT,
    input  wire logic                REFERENCE_ERROR,
    // Internal stop causes
    input  wire logic                SOFT_POSITIVE_LIMIT,
    input  wire logic                SOFT_NEGATIVE_LIMIT,
    input  wire logic                SOFT_STOP_REQUEST,
    // Ramp parameter and drive feedback
    input  wire logic [31:0]         RAMP_STEP,
    input  wire logic signed [31:0]  ACTUAL_SPEED,
    // Drive command
    output      logic signed [31:0]  SPEED_REF,
    output      logic                MODE_ACTIVE
);

    // ==========================================================
    // Declarations
    logic [PIN_W-1:0]        pins_sync;
    logic                    pos_lim;
    logic                    neg_lim;
    logic                    hardware_stop_input;
    logic                    ref_err;
    logic                    wr_setpoint;
    logic                    rd_setpoint;
    logic                    rd_status;
    logic                    any_cause;
    logic [STATUS_W-1:0]     cause_bits;
    logic signed [31:0]      ramp_goal;
    logic signed [31:0]      ramp_next;

    mode_state_t             state_ff;
    mode_state_t             nxt_state;
    logic signed [31:0]      target_ff;
    logic signed [31:0]      nxt_target;
    logic [31:0]             step_ff;
    logic [31:0]             nxt_step;
    logic signed [31:0]      ref_ff;
    logic signed [31:0]      nxt_ref;
    logic [STATUS_W-1:0]     status_ff;
    logic [STATUS_W-1:0]     nxt_status;
    logic [31:0]             rdata_ff;
    logic [31:0]             nxt_rdata;
    logic                    rvalid_ff;
    logic                    rerr_ff;
    logic                    nxt_rerr;

    // ==========================================================
    // Pin inputs pass two flops before any use
    pin_sync #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .clk      (CLK),
        .rst_n    (RST_N),
        .async_in ({REFERENCE_ERROR, HARDWARE_STOP_INPUT,
                    NEGATIVE_LIMIT_SWITCH, POSITIVE_LIMIT_SWITCH}),
        .sync_out (pins_sync)
    );

    assign pos_lim = pins_sync[0];
    assign neg_lim = pins_sync[1];
    assign hardware_stop_input = pins_sync[2];
    assign ref_err = pins_sync[3];

    // ==========================================================
    // Address decode
    assign wr_setpoint = REG_WR && (REG_INDEX == IDX_SPEED_MODE)
                         && (REG_SUBINDEX == SIDX_SETPOINT);
    assign rd_setpoint = REG_RD && (REG_INDEX == IDX_SPEED_MODE)
                         && (REG_SUBINDEX == SIDX_SETPOINT);
    assign rd_status   = REG_RD && (REG_INDEX == IDX_SPEED_MODE)
                         && (REG_SUBINDEX == SIDX_STATUS);

    // ==========================================================
    // Stop causes; no positioning range term enters here, so passing
    // the range boundaries never stops the mode
    always_comb begin
        cause_bits               = '0;
        cause_bits[ST_POS_LIMIT] = pos_lim;               // R6
        cause_bits[ST_NEG_LIMIT] = neg_lim;
        cause_bits[ST_HARDWARE_STOP_INPUT]   = hardware_stop_input;
        cause_bits[ST_REF_ERR]   = ref_err;
        cause_bits[ST_SOFT_POS]  = SOFT_POSITIVE_LIMIT;
        cause_bits[ST_SOFT_NEG]  = SOFT_NEGATIVE_LIMIT;
        cause_bits[ST_SOFT_STOP] = SOFT_STOP_REQUEST;
        any_cause                = |cause_bits;           // R8
    end

    // ==========================================================
    // Ramp generator; in a fault the reference falls to standstill
    assign ramp_goal = (state_ff == ST_FAULT) ? 32'sh0 : target_ff;

    ramp_step u_ramp_step (
        .cur_speed  (ref_ff),
        .goal_speed (ramp_goal),
        .step       (step_ff),
        .next_speed (ramp_next)
    );

    // ==========================================================
    // Mode sequencing, setpoint and ramp latch
    always_comb begin
        nxt_state  = state_ff;
        nxt_target = target_ff;
        nxt_step   = step_ff;
        nxt_ref    = ref_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_ref = ref_ff;                          // R10
            end
            ST_RUN: begin
                nxt_ref = ramp_next;                       // R2
                if (any_cause) begin
                    nxt_state = ST_FAULT;                  // R3
                end
            end
            ST_FAULT: begin
                nxt_ref = ramp_next;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // A write retargets at once, even mid-ramp
        if (wr_setpoint) begin
            nxt_target = $signed(REG_WDATA);               // R4
            nxt_state  = any_cause ? ST_FAULT : ST_RUN;    // R1 R7
            // Zero step would stall the ramp forever
            nxt_step   = (RAMP_STEP == '0) ? STEP_MIN : RAMP_STEP; // R9
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_ff  <= ST_IDLE;
            target_ff <= SETPOINT_RST;                     // R10
            step_ff   <= STEP_MIN;
            ref_ff    <= 32'sh0;
        end else begin
            state_ff  <= nxt_state;
            target_ff <= nxt_target;
            step_ff   <= nxt_step;
            ref_ff    <= nxt_ref;
        end
    end

    // ==========================================================
    // Status word; a write clears it for the new run, but an event seen
    // in the same cycle while in ST_RUN still lands (set wins over clear)
    always_comb begin
        nxt_status = status_ff;
        if (wr_setpoint) begin
            nxt_status = STATUS_RST;
        end
        if (state_ff == ST_RUN && any_cause) begin
            nxt_status              = nxt_status | cause_bits; // R6
            nxt_status[ST_END]      = 1'b1;                    // R5
            nxt_status[ST_ERR]      = 1'b1;
            nxt_status[ST_REACHED]  = 1'b0;
        end else if (state_ff == ST_RUN && !wr_setpoint
                     && ref_ff == target_ff
                     && ACTUAL_SPEED == target_ff) begin
            nxt_status[ST_REACHED]  = 1'b1;                    // R5
            nxt_status[ST_END]      = 1'b1;                    // R3
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            status_ff <= STATUS_RST;                           // R10
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ==========================================================
    // Read answers, one cycle after the strobe; status is read-only
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rerr  = 1'b0;
        if (rd_setpoint) begin
            nxt_rdata = target_ff;                             // R4
        end else if (rd_status) begin
            nxt_rdata = {16'h0000, status_ff};                 // R5
        end else if (REG_RD) begin
            nxt_rerr  = 1'b1;
        end
        if (REG_WR && !wr_setpoint) begin
            nxt_rerr  = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
            rerr_ff   <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= REG_RD;
            rerr_ff   <= nxt_rerr;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign REG_RDATA   = rdata_ff;
    assign REG_RVALID  = rvalid_ff;
    assign REG_ERR     = rerr_ff;
    assign SPEED_REF   = ref_ff;
    assign MODE_ACTIVE = state_ff[1];        // One-hot bit of ST_RUN, no gate

    // ==========================================================
    // Checks
    sequence seq_clean_start;
        wr_setpoint && !any_cause;
    endsequence

    sequence seq_run_entered;
        state_ff == ST_RUN && target_ff == $past(REG_WDATA);
    endsequence

    chk_start_run: assert property (@(posedge CLK) disable iff (!RST_N) // R1
        seq_clean_start |=> seq_run_entered)
        else $error("setpoint write did not start speed mode");

    chk_hold_speed: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        (state_ff == ST_RUN && ref_ff == target_ff && !wr_setpoint && !any_cause)
        |=> (ref_ff == $past(ref_ff)) && MODE_ACTIVE)
        else $error("held speed changed without a new setpoint");

    chk_end_on_zero: assert property (@(posedge CLK) disable iff (!RST_N) // R3
        (state_ff == ST_RUN && !wr_setpoint && !any_cause
         && ref_ff == target_ff && ACTUAL_SPEED == target_ff)
        |=> status_ff[ST_END] && status_ff[ST_REACHED] && !status_ff[ST_ERR])
        else $error("zero speed difference did not finish the mode");

    chk_read_back: assert property (@(posedge CLK) disable iff (!RST_N) // R4
        rd_setpoint |=> REG_RVALID && REG_RDATA == $past(target_ff))
        else $error("setpoint read-back wrong");

    chk_fault_flags: assert property (@(posedge CLK) disable iff (!RST_N) // R5
        (state_ff == ST_RUN && any_cause)
        |=> (status_ff[ST_END] && status_ff[ST_ERR] && state_ff == ST_FAULT)
        ##1 (ref_ff == 32'sh0 || ref_ff != $past(ref_ff)))
        else $error("fault did not end the mode with error");

    chk_cause_map: assert property (@(posedge CLK) disable iff (!RST_N) // R6
        (state_ff == ST_RUN && pos_lim) |=> status_ff[ST_POS_LIMIT])
        else $error("positive limit cause not flagged");

    chk_retarget: assert property (@(posedge CLK) disable iff (!RST_N) // R7
        (state_ff == ST_RUN && wr_setpoint && !any_cause)
        |=> (state_ff == ST_RUN && target_ff == $past(REG_WDATA))
        ##1 (ref_ff == $past(target_ff)
             || (($past(ref_ff) < $past(target_ff)) ? (ref_ff > $past(ref_ff))
                                                    : (ref_ff < $past(ref_ff)))))
        else $error("retarget while moving did not continue ramp");

    chk_ramp_latch: assert property (@(posedge CLK) disable iff (!RST_N) // R9
        !wr_setpoint |=> $stable(step_ff))
        else $error("ramp step changed without a setpoint write");

    chk_reset_idle: assert property (@(posedge CLK) // R10
        !RST_N |=> target_ff == 32'sh0 && status_ff == STATUS_RST
                   && !MODE_ACTIVE)
        else $error("reset did not clear setpoint and status");

endmodule : servo_speed_mode_control

// ==== hw/speed_mode_pkg.sv ====
/*
 Constants for the speed operating mode controller: parameter
 index/subindex of its two registers, status bit positions, reset
 values and state codes.
 Assumes one control clock and a parameter access port that names
 each register by index and subindex.
*/
package speed_mode_pkg;

    // ==========================================================
    // Register addressing (index:subindex)
    localparam logic [7:0] IDX_SPEED_MODE      = 8'h24;
    localparam logic [7:0] SIDX_SETPOINT       = 8'h01;
    localparam logic [7:0] SIDX_STATUS         = 8'h02;

    // ==========================================================
    // Widths and reset values
    localparam int         SPEED_W             = 32;
    localparam int         STATUS_W            = 16;
    localparam int         PIN_W               = 4;
    localparam logic [31:0] SETPOINT_RST       = 32'h0000_0000;
    localparam logic [15:0] STATUS_RST         = 16'h0000;
    localparam logic [31:0] STEP_MIN           = 32'h0000_0001;

    // ==========================================================
    // Status word bit positions
    localparam int         ST_POS_LIMIT        = 0;
    localparam int         ST_NEG_LIMIT        = 1;
    localparam int         ST_HARDWARE_STOP_INPUT          = 2;
    localparam int         ST_REF_ERR          = 3;
    localparam int         ST_SOFT_POS         = 5;
    localparam int         ST_SOFT_NEG         = 6;
    localparam int         ST_SOFT_STOP        = 7;
    localparam int         ST_REACHED          = 13;
    localparam int         ST_END              = 14;
    localparam int         ST_ERR              = 15;

    // ==========================================================
    // Mode states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FAULT = 3'b100
    } mode_state_t;

endpackage : speed_mode_pkg

// ==== testbench/servo_drive_model.sv ====
/*
 Behavioural model of the motor and power stage behind the speed
 reference: the actual speed follows the reference one clock late.
 Assumes the controller's clock and reset; slow mode closes half the
 gap per clock, as a heavy load would.
*/
`timescale 1ns/1ps
module servo_drive_model (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Load behaviour
    input  wire logic               slow,
    // Drive command and feedback
    input  wire logic signed [31:0] speed_ref,
    output      logic signed [31:0] actual_speed
);
    logic signed [31:0] gap;
    logic signed [31:0] nxt_speed;

    // ==========================================================
    // Speed follower; small gaps close at once so slow mode ends
    always_comb begin
        gap = speed_ref - actual_speed;
        if (slow && (gap > 32'sh1 || gap < -32'sh1)) begin
            nxt_speed = actual_speed + (gap >>> 1);
        end else begin
            nxt_speed = speed_ref;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            actual_speed <= 32'sh0;
        end else begin
            actual_speed <= nxt_speed;
        end
    end
endmodule : servo_drive_model

// ==== testbench/test_servo_speed_mode_control.sv ====
/*
 Self-checking bench for the speed mode controller: register access,
 ramps, reached and fault status, refused accesses.
 Assumes the drive model in servo_drive_model.sv; inputs change by
 non-blocking assignment at the rising clock edge.
*/
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] %0t %s", $time, msg); end end
module test_servo_speed_mode_control
    import speed_mode_pkg::*;
;
    logic               clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic [7:0]         reg_index = 8'h00, reg_subindex = 8'h00;
    logic               reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0]        reg_wdata = 32'h0, reg_rdata, ramp_step = 32'h1;
    logic               reg_rvalid, reg_err, mode_active;
    logic [6:0]         cause = 7'h00;
    logic signed [31:0] speed_ref, actual_speed;
    int                 num_errors = 0, checks = 0, cycles = 0;
    logic [31:0]        rd_data;
    logic               rd_err;
    localparam int      CAUSE_BIT [7] = '{ST_POS_LIMIT, ST_NEG_LIMIT, ST_HARDWARE_STOP_INPUT,
                                          ST_REF_ERR, ST_SOFT_POS, ST_SOFT_NEG,
                                          ST_SOFT_STOP};

    servo_speed_mode_control dut (
        .CLK(clk), .RST_N(rst_n), .REG_INDEX(reg_index), .REG_SUBINDEX(reg_subindex),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .REG_ERR(reg_err),
        .POSITIVE_LIMIT_SWITCH(cause[0]), .NEGATIVE_LIMIT_SWITCH(cause[1]),
        .HARDWARE_STOP_INPUT(cause[2]), .REFERENCE_ERROR(cause[3]),
        .SOFT_POSITIVE_LIMIT(cause[4]), .SOFT_NEGATIVE_LIMIT(cause[5]),
        .SOFT_STOP_REQUEST(cause[6]), .RAMP_STEP(ramp_step),
        .ACTUAL_SPEED(actual_speed), .SPEED_REF(speed_ref), .MODE_ACTIVE(mode_active));

    servo_drive_model drive (
        .clk(clk), .rst_n(rst_n), .slow(slow), .speed_ref(speed_ref),
        .actual_speed(actual_speed));

    // ==========================================================
    // Clock, 40 ns period, and a hang guard well above the run length
    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            stop_test();
        end
    end

    // ==========================================================
    // Register port: write returns just after the edge that takes it
    task automatic wr(input logic [7:0] sidx, input logic [31:0] data);
        @(posedge clk);
        reg_index    <= IDX_SPEED_MODE;
        reg_subindex <= sidx;
        reg_wdata    <= data;
        reg_wr       <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read; the answer lands at the taken edge and is seen here just after it
    task automatic rd(input logic [7:0] sidx);
        @(posedge clk);
        reg_index    <= IDX_SPEED_MODE;
        reg_subindex <= sidx;
        reg_rd       <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHECK(reg_rvalid, 1'b1, "read not answered")
        rd_data = reg_rdata;
        rd_err  = reg_err;
    endtask : rd

    // ==========================================================
    // Reset state and register defaults
    task automatic test_reset();
        `CHECK(speed_ref, 32'sh0, "ref after reset")
        `CHECK(mode_active, 1'b0, "mode after reset")
        rd(SIDX_SETPOINT);
        `CHECK(rd_data, SETPOINT_RST, "setpoint default")
        rd(SIDX_STATUS);
        `CHECK(rd_data, 32'h0, "status after reset")
        $display("test_reset done");
    endtask : test_reset

    // Start, ramp, hold and reached with a slow load
    task automatic test_start();
        @(posedge clk);
        slow      <= 1'b1;
        ramp_step <= 32'd40;
        wr(SIDX_SETPOINT, 32'd100);
        `CHECK(mode_active, 1'b1, "mode not entered")
        for (int i = 1; i <= 3; i++) begin
            @(posedge clk);
            #1;
            `CHECK(speed_ref, (i == 3) ? 32'sd100 : 32'sd40 * i, "ramp up")
        end
        repeat (16) @(posedge clk);
        #1;
        `CHECK(speed_ref, 32'sd100, "speed not held")
        rd(SIDX_STATUS);
        `CHECK(rd_data, 32'h0000_6000, "reached status")
        rd(SIDX_SETPOINT);
        `CHECK(rd_data, 32'd100, "setpoint readback")
        slow <= 1'b0;
        $display("test_start done");
    endtask : test_start

    // New negative setpoint while moving; ramp change after write
    task automatic test_change();
        @(posedge clk);
        ramp_step <= 32'd30;
        wr(SIDX_SETPOINT, -32'sd50);
        for (int i = 1; i <= 5; i++) begin
            @(posedge clk);
            if (i == 1) begin
                ramp_step <= 32'd1000;
            end
            #1;
            `CHECK(speed_ref, 32'sd100 - 32'sd30 * i, "ramp step")
            `CHECK(mode_active, 1'b1, "stopped on change")
        end
        // Feedback lags one clock and reached lands one clock after that
        repeat (2) @(posedge clk);
        rd(SIDX_STATUS);
        `CHECK(rd_data, 32'h0000_6000, "status after change")
        $display("test_change done");
    endtask : test_change

    // Every stop cause ends the mode with its own bit
    task automatic test_faults();
        for (int c = 0; c < 7; c++) begin
            @(posedge clk);
            ramp_step <= 32'd100;
            wr(SIDX_SETPOINT, 32'd200);
            repeat (3) @(posedge clk);
            cause <= 7'h1 << c;
            repeat (8) @(posedge clk);
            #1;
            `CHECK(speed_ref, 32'sh0, "fault ramp to zero")
            `CHECK(mode_active, 1'b0, "mode after fault")
            rd(SIDX_STATUS);
            `CHECK(rd_data[15:0], (16'h1 << CAUSE_BIT[c]) | 16'hc000, "cause bit")
            @(posedge clk);
            cause <= 7'h00;
            repeat (3) @(posedge clk);
        end
        $display("test_faults done");
    endtask : test_faults

    // Write to the status word and an unmapped read are refused
    task automatic test_refused();
        wr(SIDX_STATUS, 32'h0000_1234);
        `CHECK(reg_err, 1'b1, "status write accepted")
        rd(SIDX_STATUS);
        `CHECK(rd_data[15:0], 16'hc000 | (16'h1 << ST_SOFT_STOP), "status changed")
        rd(8'h05);
        `CHECK({rd_err, rd_data}, {1'b1, 32'h0}, "unmapped read")
        $display("test_refused done");
    endtask : test_refused

    // ==========================================================
    // Verdict, reached from the main sequence or the hang guard
    task automatic stop_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        test_reset();
        test_start();
        test_change();
        test_faults();
        test_refused();
        stop_test();
    end
endmodule : test_servo_speed_mode_control
